// [pcls_device.sv]
module pcls_device (
  input wire logic clk_i,
  input wire logic resetn_i,
  pcls_if.device link,
  output logic [1:0] mode_o,
  output logic switching_en_o,
  output logic discharge_en_o,
  output logic [5:0] level_code_o,
  output logic signed [15:0] level_mv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] line_sync;
  logic [2:0] en_sync;
  logic [2:0] fd_sync;
  logic line_s;
  logic en_s;
  logic fd_s;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_sync <= 3'h7;
      en_sync <= 3'h0;
      fd_sync <= 3'h0;
    end else begin
      line_sync <= {line_sync[1:0], link.line};
      en_sync <= {en_sync[1:0], link.enable_pin};
      fd_sync <= {fd_sync[1:0], link.discharge_select_pin};
    end
  end

  // accepted levels only change on agreement
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_s <= 1'b1;
      en_s <= 1'b0;
      fd_s <= 1'b0;
    end else begin
      if (line_sync[1] == line_sync[2]) line_s <= line_sync[2];
      if (en_sync[1] == en_sync[2]) en_s <= en_sync[2];
      if (fd_sync[1] == fd_sync[2]) fd_s <= fd_sync[2];
    end
  end

  // ----------------------------------------
  // falling-edge filter
  // ----------------------------------------
  logic [15:0] low_cnt;
  logic line_f;
  logic line_f_q;
  logic line_off;

  // a low only counts after it persists; highs pass at once so only falls are filtered
  // the counter runs on to the idle time, so a held low reads as shutdown and not as a pulse
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt <= 16'h0000;
      line_f <= 1'b1;
    end else if (line_s) begin
      low_cnt <= 16'h0000;
      line_f <= 1'b1;
    end else begin
      if (low_cnt != 16'(pcls_pkg::IDLE_CYC)) low_cnt <= low_cnt + 16'h0001;
      if (low_cnt >= 16'(pcls_pkg::GLITCH_CYC)) line_f <= 1'b0;
    end
  end

  // no pulse stays low this long, so a line held low means off
  assign line_off = (low_cnt == 16'(pcls_pkg::IDLE_CYC));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) line_f_q <= 1'b1;
    else line_f_q <= line_f;
  end

  // ----------------------------------------
  // burst counter
  // ----------------------------------------
  logic [5:0] pulse_cnt;
  logic [15:0] idle_cnt;
  logic in_burst;
  logic burst_done;
  logic [5:0] prog_level;
  logic rise_f;

  // a completed pulse is a filtered low followed by the rise
  assign rise_f = line_f && !line_f_q;

  // count pulses while enable low; the first fall is the start of a burst
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_cnt <= 6'h00;
      idle_cnt <= 16'h0000;
      in_burst <= 1'b0;
      burst_done <= 1'b0;
    end else begin
      burst_done <= 1'b0;
      if (en_s) begin
        in_burst <= 1'b0;
        pulse_cnt <= 6'h00;
      end else if (!line_f) begin
        // a held low cuts the burst; its pulses are dropped
        in_burst <= !line_off;
        idle_cnt <= 16'h0000;
        if (line_off) pulse_cnt <= 6'h00;
      end else if (rise_f) begin
        if (in_burst && pulse_cnt != 6'h3f) pulse_cnt <= pulse_cnt + 6'h01;
      end else if (in_burst) begin
        if (idle_cnt >= 16'(pcls_pkg::IDLE_CYC - 1)) begin
          in_burst <= 1'b0;
          burst_done <= 1'b1;
        end else begin
          idle_cnt <= idle_cnt + 16'h0001;
        end
      end
      if (burst_done) pulse_cnt <= 6'h00;
    end
  end

  // latch level at the end of a burst; out-of-range counts are ignored
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) prog_level <= pcls_pkg::LEVEL_DEFAULT;
    else if (burst_done && pulse_cnt != 6'h00 && pulse_cnt <= 6'(pcls_pkg::LEVEL_COUNT)) begin
      prog_level <= pulse_cnt;
    end
  end

  // ----------------------------------------
  // mode and outputs
  // ----------------------------------------
  pcls_pkg::pcls_mode_e next_mode;

  // enable high wins; with enable low only a held low line turns the converter off,
  // so burst pulses and glitches never blink the outputs
  always_comb begin
    if (en_s) next_mode = pcls_pkg::PCLS_DEFAULT;
    else if (line_off) next_mode = pcls_pkg::PCLS_OFF;
    else next_mode = pcls_pkg::PCLS_PROGRAMMED;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= pcls_pkg::PCLS_OFF;
      switching_en_o <= 1'b0;
      discharge_en_o <= 1'b0;
      level_code_o <= pcls_pkg::LEVEL_DEFAULT;
      level_mv_o <= pcls_pkg::pcls_level_mv(pcls_pkg::LEVEL_DEFAULT);
    end else begin
      mode_o <= next_mode;
      switching_en_o <= (next_mode != pcls_pkg::PCLS_OFF);
      // discharge only when off and the select pin is low
      discharge_en_o <= (next_mode == pcls_pkg::PCLS_OFF) && !fd_s;
      if (next_mode == pcls_pkg::PCLS_DEFAULT) begin
        level_code_o <= pcls_pkg::LEVEL_DEFAULT;
        level_mv_o <= pcls_pkg::pcls_level_mv(pcls_pkg::LEVEL_DEFAULT);
      end else begin
        level_code_o <= prog_level;
        level_mv_o <= pcls_pkg::pcls_level_mv(prog_level);
      end
    end
  end
endmodule : pcls_device

// [pcls_pkg.sv]
package pcls_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // timing at the 100 MHz system clock
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int MAX_PULSE_HZ = 250_000;
  // one full pulse period at the highest accepted rate, in cycles
  localparam int PULSE_PERIOD_CYC = CLK_HZ / MAX_PULSE_HZ;
  // low and high halves of a master pulse, half a period each
  localparam int HALF_PERIOD_CYC = PULSE_PERIOD_CYC / 2;
  // glitch filter on falling edges: a low must persist this long, in ns
  localparam int GLITCH_NS = 500;
  localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // idle high time that closes a burst, in us
  localparam int IDLE_US = 20;
  localparam int IDLE_CYC = IDLE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------
  // level table
  // ----------------------------------------
  localparam int LEVEL_COUNT = 41;
  localparam logic [5:0] LEVEL_DEFAULT = 6'h10;
  localparam int STEP_MV = 100;
  localparam int MOST_NEG_MV = -6400;

  // output mode of the converter
  typedef enum logic [1:0] {
    PCLS_OFF = 2'b00,
    PCLS_DEFAULT = 2'b01,
    PCLS_PROGRAMMED = 2'b11
  } pcls_mode_e;

  // level code to millivolts
  function automatic logic signed [15:0] pcls_level_mv(input logic [5:0] code);
    int mv;
    mv = MOST_NEG_MV + (int'(code) - 1) * STEP_MV;
    return 16'(mv);
  endfunction : pcls_level_mv
endpackage : pcls_pkg

// [pcls_if.sv]
interface pcls_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic line_o;
  logic line_oe_n;
  logic enable_pin;
  logic discharge_select_pin;
  // open-drain-free push line, master drives when oe low; idle pulled high
  wire line = line_oe_n ? 1'b1 : line_o;
  modport device (input line, input enable_pin, input discharge_select_pin);
  modport master (output line_o, output line_oe_n, output enable_pin, output discharge_select_pin);
endinterface : pcls_if

// [pcls_master.sv]
module pcls_master (
  input wire logic clk_i,
  input wire logic resetn_i,
  pcls_if.master link,
  input wire logic start_i,
  input wire logic [5:0] count_i,
  input wire logic enable_i,
  input wire logic discharge_sel_i,
  input wire logic line_idle_i,
  output logic busy_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // pulse sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCLS_M_IDLE = 2'b00,
    PCLS_M_LOW = 2'b01,
    PCLS_M_HIGH = 2'b11,
    PCLS_M_STOP = 2'b10
  } pcls_mstate_e;

  pcls_mstate_e state;
  logic [15:0] tick;
  logic [5:0] left;

  // one pulse is half period low, half high, never faster than the max rate
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= PCLS_M_IDLE;
      tick <= 16'h0000;
      left <= 6'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        PCLS_M_IDLE: begin
          if (start_i && !enable_i && count_i != 6'h00) begin
            state <= PCLS_M_LOW;
            left <= count_i;
            tick <= 16'h0000;
            busy_o <= 1'b1;
          end
        end
        PCLS_M_LOW: begin
          if (tick >= 16'(pcls_pkg::HALF_PERIOD_CYC - 1)) begin
            state <= PCLS_M_HIGH;
            tick <= 16'h0000;
            left <= left - 6'h01;
          end else tick <= tick + 16'h0001;
        end
        PCLS_M_HIGH: begin
          if (tick >= 16'(pcls_pkg::HALF_PERIOD_CYC - 1)) begin
            tick <= 16'h0000;
            state <= (left == 6'h00) ? PCLS_M_STOP : PCLS_M_LOW;
          end else tick <= tick + 16'h0001;
        end
        PCLS_M_STOP: begin
          // stop: hold the line high long enough to close the burst
          if (tick >= 16'(pcls_pkg::IDLE_CYC * 2)) begin
            state <= PCLS_M_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else tick <= tick + 16'h0001;
        end
      endcase
    end
  end

  // master alone drives the line; low pulses, high for the rest of a burst, else line_idle_i
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.line_o <= 1'b0;
      link.line_oe_n <= 1'b0;
      link.enable_pin <= 1'b0;
      link.discharge_select_pin <= 1'b0;
    end else begin
      link.line_oe_n <= 1'b0;
      link.line_o <= (state == PCLS_M_LOW) ? 1'b0 : ((state != PCLS_M_IDLE) || line_idle_i);
      link.enable_pin <= enable_i && (state == PCLS_M_IDLE);
      link.discharge_select_pin <= discharge_sel_i;
    end
  end
endmodule : pcls_master

// [pcls_asserts.sv]
module pcls_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic line,
  input wire logic line_oe_n,
  input wire logic enable_pin,
  input wire logic discharge_select_pin,
  input wire logic [1:0] mode_o,
  input wire logic switching_en_o,
  input wire logic discharge_en_o,
  input wire logic [5:0] level_code_o,
  input wire logic signed [15:0] level_mv_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [11:0] hi_cnt;
  // idle-high time; saturates so long idles never wrap back below the latch time
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) hi_cnt <= 12'h0;
    else if (!line) hi_cnt <= 12'h0;
    else if (hi_cnt != 12'hfff) hi_cnt <= hi_cnt + 12'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_en_hold; enable_pin [*8]; endsequence
  sequence s_off_dis; (mode_o == pcls_pkg::PCLS_OFF && !discharge_select_pin) [*8]; endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_dir; !line_oe_n; endproperty
  a_dir: assert property (p_dir) else $error("line released by master");
  property p_low; $fell(line) |=> !line [*8]; endproperty
  a_low: assert property (p_low) else $error("line low too short");
  property p_sw; mode_o == pcls_pkg::PCLS_OFF |-> !switching_en_o; endproperty
  a_sw: assert property (p_sw) else $error("switching while off");
  property p_dis; s_off_dis |-> discharge_en_o; endproperty
  a_dis: assert property (p_dis) else $error("no discharge when off");
  property p_nodis; discharge_select_pin [*8] |-> !discharge_en_o; endproperty
  a_nodis: assert property (p_nodis) else $error("discharge with select high");
  property p_mv; $stable(level_code_o) |-> level_mv_o == 16'(-6400 + (int'(level_code_o) - 1) * 100); endproperty
  a_mv: assert property (p_mv) else $error("millivolts off the step");
  property p_rng; level_code_o inside {[6'h01:6'h29]}; endproperty
  a_rng: assert property (p_rng) else $error("level code out of range");
  property p_def; s_en_hold |-> mode_o == pcls_pkg::PCLS_DEFAULT && level_code_o == 6'h10; endproperty
  a_def: assert property (p_def) else $error("enable high not default");
  property p_late; $changed(level_code_o) && $stable(mode_o) |-> hi_cnt >= 12'h7d0; endproperty
  a_late: assert property (p_late) else $error("level applied before idle");
endmodule : pcls_asserts

// [pulse_count_level_select_bench.sv]
module pulse_count_level_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start_i = 1'b0;
  logic [5:0] count_i = 6'h01;
  logic enable_i = 1'b0;
  logic discharge_sel_i = 1'b1;
  logic line_idle_i = 1'b1;
  logic busy_o, done_o, switching_en_o, discharge_en_o;
  logic [1:0] mode_o;
  logic [5:0] level_code_o, last, falls;
  logic signed [15:0] level_mv_o;
  logic [31:0] seed = 32'h6;
  int fails = 0;
  int tests_run = 0;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  always #5 clk_i = ~clk_i;
  pcls_if bus ();
  pcls_device u_pcls_device (.clk_i(clk_i), .resetn_i(resetn_i), .link(bus), .mode_o(mode_o),
    .switching_en_o(switching_en_o), .discharge_en_o(discharge_en_o), .level_code_o(level_code_o),
    .level_mv_o(level_mv_o));
  pcls_master u_pcls_master (.clk_i(clk_i), .resetn_i(resetn_i), .link(bus), .start_i(start_i), .count_i(count_i),
    .enable_i(enable_i), .discharge_sel_i(discharge_sel_i), .line_idle_i(line_idle_i), .busy_o(busy_o),
    .done_o(done_o));
  pcls_asserts u_pcls_asserts (.clk_i(clk_i), .resetn_i(resetn_i), .line(bus.line), .line_oe_n(bus.line_oe_n),
    .enable_pin(bus.enable_pin), .discharge_select_pin(bus.discharge_select_pin), .mode_o(mode_o),
    .switching_en_o(switching_en_o), .discharge_en_o(discharge_en_o), .level_code_o(level_code_o),
    .level_mv_o(level_mv_o));
  // pulses seen on the wire, cleared before each burst
  always @(negedge bus.line) falls = falls + 6'h1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand
  function automatic logic signed [15:0] exp_mv(input logic [5:0] c);
    return 16'(-6400 + (int'(c) - 1) * 100);
  endfunction : exp_mv
  // a count of zero or beyond the table leaves the stored level alone
  function automatic logic [5:0] exp_level(input logic [5:0] c, input logic [5:0] prev);
    return (c != 6'h00 && c <= 6'(pcls_pkg::LEVEL_COUNT)) ? c : prev;
  endfunction : exp_level
  task results;
    $display("tests %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // one burst; done bounds the wait since it follows the device latch time
  task prog(input logic [5:0] c);
    int i;
    @(negedge clk_i);
    falls = 6'h0;
    count_i = c;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    for (i = 0; i < 25000 && done_o !== 1'b1; i++) @(negedge clk_i);
    if (done_o !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t no done", $time);
      results();
    end
    repeat (8) @(negedge clk_i);
    last = exp_level(c, last);
    `CHK(falls, c)
    `CHK(mode_o, pcls_pkg::PCLS_PROGRAMMED)
    `CHK(level_code_o, last)
    `CHK(level_mv_o, exp_mv(last))
    `CHK(switching_en_o, 1'b1)
    $display("burst %0d done", c);
  endtask : prog
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (20) @(negedge clk_i);
    `CHK(level_code_o, 6'h10)
    `CHK(bus.line_oe_n, 1'b0)
    prog(6'h01);
    prog(6'h29);
    prog(6'h2a);
    prog(6'h10);
    repeat (3) prog(6'(next_rand() % 32'hc + 32'h2));
    // short low pulse must be filtered out
    line_idle_i = 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK(mode_o, pcls_pkg::PCLS_PROGRAMMED)
    line_idle_i = 1'b1;
    repeat (2100) @(negedge clk_i);
    `CHK(level_code_o, last)
    $display("glitch done");
    enable_i = 1'b1;
    repeat (10) @(negedge clk_i);
    `CHK(mode_o, pcls_pkg::PCLS_DEFAULT)
    `CHK(level_mv_o, exp_mv(6'h10))
    enable_i = 1'b0;
    repeat (10) @(negedge clk_i);
    `CHK(level_code_o, last)
    $display("enable done");
    line_idle_i = 1'b0;
    repeat (2100) @(negedge clk_i);
    `CHK(mode_o, pcls_pkg::PCLS_OFF)
    `CHK(switching_en_o, 1'b0)
    `CHK(discharge_en_o, 1'b0)
    discharge_sel_i = 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK(discharge_en_o, 1'b1)
    enable_i = 1'b1;
    repeat (10) @(negedge clk_i);
    `CHK(mode_o, pcls_pkg::PCLS_DEFAULT)
    $display("shutdown done");
    results();
  end
endmodule : pulse_count_level_select_bench
